// [core/sfpi_pkg.sv]
// constants and types shared by the serial flash pin interface
package sfpi_pkg;

  // ============================================================
  // data path
  localparam int BYTE_W = 8;
  localparam int RX_BUF_DEPTH = 2;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // ============================================================
  // pin positions inside the four-bit data bus
  localparam int IO_SI = 0;
  localparam int IO_SO = 1;
  localparam int IO_WP = 2;
  localparam int IO_HOLD = 3;
  localparam logic [3:0] OE_N_ALL_OFF = 4'hf;
  localparam logic [3:0] IO_OUT_RST = 4'hf;

  // ============================================================
  // synchroniser layout {cs_n, sck, io[3:0]} and its reset value, select high and clock low
  localparam int SYNC_W = 6;
  localparam int SYNC_CS = 5;
  localparam int SYNC_SCK = 4;
  localparam logic [5:0] SYNC_RST = 6'h2f;

  // ============================================================
  // protection decode: lock bits that enable the protect pin
  localparam logic QUAD_OFF = 1'b0;
  localparam logic LOCK_HI_PROT = 1'b0;
  localparam logic LOCK_LO_PROT = 1'b1;

  // ============================================================
  // output lane formats and frame states
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL = 2'h1,
    LANE_QUAD = 2'h2
  } sfpi_lane_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_HOLD = 3'h4
  } sfpi_state_t;

endpackage

// [core/sfpi_buf.sv]
// two-entry receive buffer with valid and ready on both sides
`timescale 1ns/1ps
module sfpi_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input logic sys_clk, // system clock
  input logic resetn, // async reset, active low
  input logic wr_valid, // write request
  output logic wr_ready, // room for one more word
  input logic [WIDTH-1:0] wr_data, // word to store
  output logic rd_valid, // a word is waiting
  input logic rd_ready, // reader takes the word
  output logic [WIDTH-1:0] rd_data // oldest word, from storage
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest flags from the fill count
  assign wr_ready = (count != FULL_CNT);
  assign rd_valid = (count != '0);
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign rd_data = mem[rd_ptr];

  // storage, written only when there is room
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= ptr_step(wr_ptr);
      end
      if (do_rd) begin
        rd_ptr <= ptr_step(rd_ptr);
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// [core/sfpi_core.sv]
// serial flash pin interface: framing, edge sampling, lane driving, protect pin
`timescale 1ns/1ps
module sfpi_core
  import sfpi_pkg::*;
(
  input logic sys_clk, // system clock, 125 MHz
  input logic resetn, // async reset, active low
  input logic cs_n_pin, // select pin, active low
  input logic sck_pin, // serial clock pin
  input logic [3:0] io_in, // data pin levels, pull-ups resolved
  output logic [3:0] io_out, // data pin drive values
  output logic [3:0] io_oe_n, // data pin enables, low drives
  input logic quad_mode_bit, // quad format enabled
  input logic status_lock_hi, // status lock high bit
  input logic status_lock_lo, // status lock low bit
  input logic op_busy, // internal program or erase running
  input sfpi_lane_t lane_mode, // output lane format
  input logic tx_enable, // device drives read data
  input logic [7:0] tx_data, // next byte to send
  input logic tx_valid, // tx_data holds a byte
  output logic tx_ready, // byte taken this cycle
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // received byte waiting
  input logic rx_ready, // received byte taken
  output logic rx_overrun, // byte lost, buffer full
  output logic frame_start, // select fell, one cycle
  output logic frame_end, // select rose, one cycle
  output logic selected, // frame in progress
  output logic standby, // idle and not busy
  output logic status_write_blocked // protect pin blocks status writes
);
  // ============================================================
  // pin synchroniser and edge finders
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] sync_prev;
  logic cs_s;
  logic sck_s;
  logic [3:0] io_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic hold_fall;
  logic hold_rise;

  // two flops for every pin, a third for edge history
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      sync_prev <= SYNC_RST;
    end else begin
      sync_a <= {cs_n_pin, sck_pin, io_in};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // edges on the synchronised levels
  assign cs_s = sync_b[SYNC_CS];
  assign sck_s = sync_b[SYNC_SCK];
  assign io_s = sync_b[3:0];
  assign sck_rise = sck_s && !sync_prev[SYNC_SCK];
  assign sck_fall = !sck_s && sync_prev[SYNC_SCK];
  assign cs_fall = !cs_s && sync_prev[SYNC_CS];
  assign cs_rise = cs_s && !sync_prev[SYNC_CS];
  assign hold_fall = !io_s[IO_HOLD] && sync_prev[IO_HOLD];
  assign hold_rise = io_s[IO_HOLD] && !sync_prev[IO_HOLD];

  // ============================================================
  // frame state
  sfpi_state_t state;
  sfpi_state_t next_state;

  // frame sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cs_s) begin
          next_state = ST_IDLE;
        end else if (hold_fall && !sck_s && quad_mode_bit == QUAD_OFF) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cs_s) begin
          next_state = ST_IDLE;
        end else if (hold_rise) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // status outputs and frame pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_start <= 1'b0;
      frame_end <= 1'b0;
      standby <= 1'b1;
      status_write_blocked <= 1'b0;
    end else begin
      frame_start <= (state == ST_IDLE) && cs_fall;
      frame_end <= (state != ST_IDLE) && cs_s;
      standby <= cs_s && !op_busy;
      status_write_blocked <= (quad_mode_bit == QUAD_OFF) && (status_lock_hi == LOCK_HI_PROT)
          && (status_lock_lo == LOCK_LO_PROT) && !io_s[IO_WP];
    end
  end

  assign selected = (state != ST_IDLE);

  // ============================================================
  // receive path
  logic [7:0] rx_shift;
  logic [2:0] rx_cnt;
  logic rx_push;
  logic [7:0] rx_word;
  logic buf_ready;
  logic rx_take;

  // rx sampling only while selected and line zero is an input
  assign rx_take = (state == ST_ACTIVE) && sck_rise && io_oe_n[IO_SI];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_shift <= '0;
      rx_cnt <= BIT_CNT_ZERO;
      rx_push <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_push <= 1'b0;
      if (frame_start) begin
        rx_cnt <= BIT_CNT_ZERO;
      end else if (rx_take) begin
        rx_shift <= {rx_shift[6:0], io_s[IO_SI]};
        rx_cnt <= rx_cnt + 1'b1;
        if (rx_cnt == BIT_CNT_LAST) begin
          rx_word <= {rx_shift[6:0], io_s[IO_SI]};
          rx_push <= 1'b1;
        end
      end
    end
  end

  // overrun flag, a new loss wins over the clear at frame start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_overrun <= 1'b0;
    end else if (rx_push && !buf_ready) begin
      rx_overrun <= 1'b1;
    end else if (frame_start) begin
      rx_overrun <= 1'b0;
    end
  end

  sfpi_buf #(
    .WIDTH(BYTE_W),
    .DEPTH(RX_BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wr_valid(rx_push),
    .wr_ready(buf_ready),
    .wr_data(rx_word),
    .rd_valid(rx_valid),
    .rd_ready(rx_ready),
    .rd_data(rx_data)
  );

  // ============================================================
  // transmit path
  logic [7:0] tx_shift;
  logic [2:0] tx_cnt;
  logic tx_step;
  logic [7:0] cur_byte;
  logic [3:0] next_io_out;
  logic [3:0] next_oe_n;
  logic drive;

  function automatic logic [2:0] lane_bits(input sfpi_lane_t m);
    case (m)
      LANE_DUAL: lane_bits = 3'h2;
      LANE_QUAD: lane_bits = 3'h4;
      default: lane_bits = 3'h1;
    endcase
  endfunction

  assign drive = (state == ST_ACTIVE) && tx_enable;
  assign tx_step = drive && sck_fall;
  assign tx_ready = tx_step && (tx_cnt == BIT_CNT_ZERO);
  assign cur_byte = (tx_cnt == BIT_CNT_ZERO) ? (tx_valid ? tx_data : FILL_BYTE) : tx_shift;

  // lane mapping of the top bits of the current byte
  always_comb begin
    next_io_out = io_out;
    case (lane_mode)
      LANE_DUAL: next_io_out[1:0] = cur_byte[7:6];
      LANE_QUAD: next_io_out = cur_byte[7:4];
      default: next_io_out[IO_SO] = cur_byte[7];
    endcase
  end

  // enables: SO in any read, line zero in dual or quad, lines two, three in quad with quad_mode_bit set
  always_comb begin
    next_oe_n = OE_N_ALL_OFF;
    if (drive) begin
      next_oe_n[IO_SO] = 1'b0;
      if (lane_mode != LANE_SINGLE) begin
        next_oe_n[IO_SI] = 1'b0;
      end
      if (lane_mode == LANE_QUAD && quad_mode_bit) begin
        next_oe_n[3:2] = 2'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_shift <= '0;
      tx_cnt <= BIT_CNT_ZERO;
      io_out <= IO_OUT_RST;
    end else begin
      if (frame_start) begin
        tx_cnt <= BIT_CNT_ZERO;
      end else if (tx_step) begin
        io_out <= next_io_out;
        tx_shift <= cur_byte << lane_bits(lane_mode);
        tx_cnt <= tx_cnt + lane_bits(lane_mode);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_oe_n <= OE_N_ALL_OFF;
    end else begin
      io_oe_n <= next_oe_n;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_DESELECT_FLOAT: assert property (
    $past(state) == ST_IDLE |-> io_oe_n == OE_N_ALL_OFF)
    else $error("data pins driven while deselected");
  AST_START_ON_FALL: assert property (
    $past(state) == ST_IDLE && state == ST_ACTIVE |-> $past(cs_fall))
    else $error("frame started without select falling");
  AST_END_ON_RISE: assert property (
    state != ST_IDLE && cs_s |=> state == ST_IDLE && frame_end)
    else $error("frame not ended by select rising");
  AST_STANDBY_WAIT: assert property (
    op_busy |=> !standby)
    else $error("standby while internal operation busy");
  AST_RX_ON_RISE: assert property (
    rx_push |-> $past(sck_rise) && $past(state) == ST_ACTIVE)
    else $error("byte completed without a clock rising edge");
  AST_TX_ON_FALL: assert property (
    io_out != $past(io_out) |-> $past(sck_fall))
    else $error("output changed away from clock falling edge");
  AST_IDLE_NO_EFFECT: assert property (
    state == ST_IDLE && !cs_fall |=> $stable(rx_cnt) && $stable(tx_cnt))
    else $error("bit counters moved while deselected");
  AST_QUAD_NIBBLE: assert property (
    tx_ready && tx_valid && lane_mode == LANE_QUAD |=> io_out == $past(tx_data[7:4]))
    else $error("quad read did not drive upper nibble");
  AST_DUAL_SO: assert property (
    drive && lane_mode == LANE_DUAL |=> !io_oe_n[IO_SO] && !io_oe_n[IO_SI])
    else $error("dual read not driving both lines");
  AST_WP_BLOCK: assert property (
    status_write_blocked |-> !$past(quad_mode_bit) && $past(status_lock_lo)
      && !$past(status_lock_hi) && !$past(io_s[IO_WP]))
    else $error("status write blocked without protection enabled");
  AST_QUAD_LINE_TWO: assert property (
    !io_oe_n[IO_WP] |-> $past(quad_mode_bit) && $past(lane_mode) == LANE_QUAD)
    else $error("protect pin driven outside quad mode");
  AST_HOLD_PAUSE: assert property (
    state == ST_HOLD |=> $stable(rx_cnt) && $stable(tx_shift))
    else $error("sequence advanced during hold");

  COV_FRAME: cover property (frame_start ##[1:1000] frame_end);
  COV_RX_BYTE: cover property (rx_push && buf_ready);
  COV_QUAD_READ: cover property (tx_ready && lane_mode == LANE_QUAD);
  COV_HOLD: cover property (state == ST_ACTIVE ##1 state == ST_HOLD);
  COV_OVERRUN: cover property ($rose(rx_overrun));

endmodule

// [testbench/sfpi_host_model.sv]
// spi host model driving select, serial clock and data lines
`timescale 1ns/1ps
module sfpi_host_model (
  output logic cs_n, // select, active low
  output logic sck, // serial clock, parked high
  output logic [3:0] io_drv, // data drive values
  output logic [3:0] io_oe_n, // data enables, low drives
  input wire logic [3:0] io_line // resolved pin levels
);
  localparam time HALF = 80ns;

  // ============================================================
  // idle: deselected, clock still, lines released to pull-ups
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    io_drv = 4'hf;
    io_oe_n = 4'hf;
  end

  // falling select opens a frame
  task automatic begin_frame();
    cs_n = 1'b0;
    #(2 * HALF);
  endtask

  // release lines, then rising select after the last bit
  task automatic end_frame();
    #HALF;
    io_oe_n[1:0] = 2'b11;
    cs_n = 1'b1;
    #(4 * HALF);
  endtask

  // protect pin pulled low, or left to its pull-up
  task automatic set_protect(input logic low);
    io_drv[2] = 1'b0;
    io_oe_n[2] = !low;
  endtask

  // one byte: out on line zero in single mode, lines released otherwise
  task automatic xfer(input logic [7:0] mosi, input int lanes, output logic [7:0] got);
    got = 8'h00;
    io_oe_n[3:1] = 3'b111;
    io_oe_n[0] = (lanes == 1) ? 1'b0 : 1'b1;
    for (int i = 0; i < 8 / lanes; i++) begin
      sck = 1'b0;
      io_drv[0] = mosi[7 - i];
      #HALF;
      // host samples on the rising edge
      sck = 1'b1;
      case (lanes)
        1: got = {got[6:0], io_line[1]};
        2: got = {got[5:0], io_line[1:0]};
        default: got = {got[3:0], io_line};
      endcase
      #HALF;
    end
  endtask

  // pause with the clock low, clock and line zero toggle meanwhile, clock left low
  task automatic pause_frame(input int n);
    sck = 1'b0;
    #HALF;
    io_drv[3] = 1'b0;
    io_oe_n[3] = 1'b0;
    #(2 * HALF);
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      io_drv[0] = ~io_drv[0];
      #HALF;
      sck = 1'b0;
      #HALF;
    end
    io_oe_n[3] = 1'b1;
    #(2 * HALF);
  endtask
endmodule

// [testbench/test_serial_flash_pin_interface.sv]
// self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
module test_serial_flash_pin_interface
  import sfpi_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n_pin, sck_pin, tx_ready, rx_valid, rx_overrun, frame_start, frame_end;
  logic selected, standby, status_write_blocked;
  logic quad_mode_bit, status_lock_hi, status_lock_lo, op_busy, tx_enable, tx_valid, rx_ready;
  logic [3:0] io_in, io_out, io_oe_n, h_drv, h_oe_n;
  logic [7:0] tx_data, rx_data;
  sfpi_lane_t lane_mode;
  logic [31:0] seed = 32'h0000_0058;
  logic [3:0] oe_want [3] = '{4'hd, 4'hc, 4'h0};
  int failures = 0;
  int n_checks = 0;
  int n_fs = 0;
  int n_fe = 0;
  logic [7:0] exp_rx[$];
  logic [7:0] exp_tx[$];

  always #4 sys_clk = ~sys_clk;

  // pin resolution with pull-ups on every data line
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = !io_oe_n[i] ? io_out[i] : (!h_oe_n[i] ? h_drv[i] : 1'b1);
    end
  end

  sfpi_host_model host (.cs_n(cs_n_pin), .sck(sck_pin), .io_drv(h_drv), .io_oe_n(h_oe_n),
    .io_line(io_in));

  sfpi_core dut (.sys_clk(sys_clk), .resetn(resetn), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .quad_mode_bit(quad_mode_bit),
    .status_lock_hi(status_lock_hi), .status_lock_lo(status_lock_lo), .op_busy(op_busy),
    .lane_mode(lane_mode), .tx_enable(tx_enable), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .frame_start(frame_start), .frame_end(frame_end),
    .selected(selected), .standby(standby), .status_write_blocked(status_write_blocked));

  // ============================================================
  // helpers
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one host byte; note the word the device should keep
  task automatic host_byte(input int lanes, input bit keep);
    logic [7:0] mosi;
    logic [7:0] got;
    mosi = rnd8();
    if (keep) exp_rx.push_back(mosi);
    host.xfer(mosi, lanes, got);
    if (tx_enable) check(got, exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hxx);
  endtask

  // ============================================================
  // receive monitor: oldest note against each word handed over
  always @(posedge sys_clk) begin
    if (resetn && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hxx);
    end
  end

  // frame pulse counters, one count per one-cycle pulse
  always @(posedge sys_clk) begin
    if (frame_start === 1'b1) n_fs++;
    if (frame_end === 1'b1) n_fe++;
  end

  // transmit feeder: note each byte taken, offer a fresh one
  always @(posedge sys_clk) begin
    if (tx_ready === 1'b1 && tx_valid === 1'b1) begin
      exp_tx.push_back(tx_data);
      #1 tx_data = rnd8();
    end
  end

  // watchdog
  initial begin
    #300_000;
    failures++;
    tally_and_finish();
  end

  // ============================================================
  // main sequence
  initial begin
    {quad_mode_bit, status_lock_hi, status_lock_lo, op_busy, tx_enable} = 5'h00;
    lane_mode = LANE_SINGLE;
    tx_data = 8'h00;
    tx_valid = 1'b1;
    rx_ready = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    tx_data = rnd8();
    step(2);
    // single-line receive, back-to-back bytes
    host.begin_frame();
    check({6'h00, selected, standby}, 8'h02);
    check(8'(io_oe_n), 8'h0f);
    repeat (3) host_byte(1, 1'b1);
    host.end_frame();
    check({6'h00, selected, standby}, 8'h01);
    $display("test rx_single done");
    // clock and data activity while deselected
    host_byte(1, 1'b0);
    step(4);
    check({6'h00, rx_valid, selected}, 8'h00);
    check(8'(io_oe_n), 8'h0f);
    $display("test deselected done");
    // receiver stalls: third byte dropped, two kept
    rx_ready = 1'b0;
    host.begin_frame();
    host_byte(1, 1'b1);
    host_byte(1, 1'b1);
    host_byte(1, 1'b0);
    host.end_frame();
    check({7'h00, rx_overrun}, 8'h01);
    step(1);
    rx_ready = 1'b1;
    step(4);
    check({7'h00, rx_valid}, 8'h00);
    host.begin_frame();
    check({7'h00, rx_overrun}, 8'h00);
    host.end_frame();
    $display("test overrun done");
    // read data over one, two and four lines
    for (int m = 0; m < 3; m++) begin
      lane_mode = sfpi_lane_t'(m);
      quad_mode_bit = (m == 2);
      tx_enable = 1'b1;
      host.begin_frame();
      check(8'(io_oe_n), 8'(oe_want[m]));
      repeat (2) host_byte(1 << m, m == 0);
      host.end_frame();
      check(8'(io_oe_n), 8'h0f);
    end
    tx_enable = 1'b0;
    lane_mode = LANE_SINGLE;
    quad_mode_bit = 1'b0;
    $display("test read lanes done");
    // protect pin decode over every mode, lock and pin combination
    for (int k = 0; k < 16; k++) begin
      {quad_mode_bit, status_lock_hi, status_lock_lo} = 3'(k >> 1);
      host.set_protect(k[0]);
      step(6);
      check({7'h00, status_write_blocked}, {7'h00, k == 3});
    end
    host.set_protect(1'b0);
    {quad_mode_bit, status_lock_hi, status_lock_lo} = 3'b000;
    $display("test protect done");
    // busy internal operation keeps the device out of standby
    op_busy = 1'b1;
    host.begin_frame();
    host.end_frame();
    check({7'h00, standby}, 8'h00);
    op_busy = 1'b0;
    step(4);
    check({7'h00, standby}, 8'h01);
    $display("test standby done");
    // hold pauses the frame between bytes, clock ignored meanwhile
    host.begin_frame();
    host_byte(1, 1'b1);
    host.pause_frame(3);
    check({6'h00, selected, rx_valid}, 8'h02);
    host_byte(1, 1'b1);
    host.end_frame();
    $display("test hold done");
    check(8'(n_fs), 8'h08);
    check(8'(n_fe), 8'h08);
    step(4);
    tally_and_finish();
  end
endmodule
